// ---- core/cpu_regs_pkg.sv ----
package cpu_regs_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_BUS_W = 23;
  localparam int STATUS_W = 16;
  localparam int NUM_DATA_REGS = 8;
  localparam int NUM_ADDR_REGS = 7;
  localparam int REG_SEL_W = 4;
  localparam logic [REG_SEL_W-1:0] SEL_ACTIVE_STACK = 4'hf;

  // Status word fields
  localparam int SW_TRACE_BIT = 15;
  localparam int SW_SUPER_BIT = 13;
  localparam int SW_MASK_LO = 8;
  localparam int SW_MASK_W = 3;
  localparam int SW_EXTEND_BIT = 4;
  localparam int SW_NEG_BIT = 3;
  localparam int SW_ZERO_BIT = 2;
  localparam int SW_OVFL_BIT = 1;
  localparam int SW_CARRY_BIT = 0;
  localparam logic [15:0] SW_IMPL_MASK = 16'ha71f;
  localparam logic [15:0] STATUS_RESET = 16'h2700;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b10
  } op_size_e;

  typedef enum logic [3:0] {
    MODE_DATA_DIRECT = 4'b0000,
    MODE_ADDR_DIRECT = 4'b0001,
    MODE_INDIRECT = 4'b0010,
    MODE_POSTINC = 4'b0011,
    MODE_PREDEC = 4'b0100,
    MODE_OFFSET = 4'b0101,
    MODE_INDEXED = 4'b0110,
    MODE_ABS_SHORT = 4'b0111,
    MODE_ABS_LONG = 4'b1000,
    MODE_PC_OFFSET = 4'b1001,
    MODE_PC_INDEXED = 4'b1010,
    MODE_IMMEDIATE = 4'b1011,
    MODE_QUICK = 4'b1100,
    MODE_IMPLIED = 4'b1101
  } addr_mode_e;

  typedef enum logic [1:0] {
    IMPL_STATUS = 2'b00,
    IMPL_USER_STACK = 2'b01,
    IMPL_ACTIVE_STACK = 2'b10,
    IMPL_PC = 2'b11
  } implied_sel_e;

  localparam logic [2:0] STEP_BYTE = 3'h1;
  localparam logic [2:0] STEP_WORD = 3'h2;
  localparam logic [2:0] STEP_LONG = 3'h4;

endpackage

// ---- core/ea_step_calc.sv ----
`timescale 1ns/100ps
module ea_step_calc
  import cpu_regs_pkg::*;
(
  input wire logic [1:0] size,
  input wire logic is_stack,
  output logic [31:0] step
);

  always_comb
  begin
    step = {29'h0000_0000, STEP_LONG};
    if (size == SIZE_BYTE)
    begin
      // Stack pointer stays word aligned
      step = {29'h0000_0000, is_stack ? STEP_WORD : STEP_BYTE};
    end
    else if (size == SIZE_WORD)
    begin
      step = {29'h0000_0000, STEP_WORD};
    end
  end

endmodule // ea_step_calc

// ---- core/cpu_register_model_ea_gen.sv ----
`timescale 1ns/100ps
module cpu_register_model_ea_gen
  import cpu_regs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic EA_START,
  input wire logic [3:0] EA_MODE,
  input wire logic [1:0] OP_SIZE,
  input wire logic [2:0] EA_REG,
  input wire logic [3:0] INDEX_SEL,
  input wire logic INDEX_LONG,
  input wire logic [1:0] IMPLIED_SEL,
  input wire logic [15:0] EXT_WORD0,
  input wire logic [15:0] EXT_WORD1,
  input wire logic [7:0] QUICK_DATA,
  input wire logic WR_EN,
  input wire logic [3:0] WR_SEL,
  input wire logic [1:0] WR_SIZE,
  input wire logic [31:0] WR_DATA,
  input wire logic PC_WR,
  input wire logic [31:0] PC_DATA,
  input wire logic SW_WR,
  input wire logic [15:0] SW_DATA,
  input wire logic USP_WR,
  input wire logic [31:0] USP_DATA,
  output logic [22:0] ADDR_BUS,
  output logic [31:0] EFFECTIVE_ADDR,
  output logic [31:0] OPERAND,
  output logic EA_VALID,
  output logic MEM_ACCESS,
  output logic [15:0] STATUS_WORD,
  output logic [31:0] PROGRAM_COUNTER,
  output logic [2:0] INT_MASK,
  output logic TRACE_MODE,
  output logic SUPERVISOR
);

  // Index 0..7 data, 8..14 address, 15 the active stack pointer
  typedef struct packed {
    logic [15:0][31:0] regs;
    logic [31:0] user_stack_ptr;
    logic [31:0] super_stack_ptr;
    logic [31:0] program_counter;
    logic [15:0] status_word;
    logic [31:0] effective_addr;
    logic [31:0] operand;
    logic ea_valid;
    logic mem_access;
  } state_s;

  state_s st;
  state_s next_st;
  logic [31:0] step;
  logic [31:0] base_reg;
  logic [31:0] index_val;
  logic [31:0] long_displacement;
  logic [31:0] short_displacement;
  logic [31:0] active_stack_ptr;
  logic is_stack;

  ea_step_calc u_step (
    .size(OP_SIZE),
    .is_stack(is_stack),
    .step(step)
  );

  function automatic logic [31:0] read_reg(input state_s s, input logic [3:0] sel);
    logic [31:0] v;
    v = s.regs[sel];
    if (sel == SEL_ACTIVE_STACK)
    begin
      v = s.status_word[SW_SUPER_BIT] ? s.super_stack_ptr : s.user_stack_ptr;
    end
    return v;
  endfunction

  always_comb
  begin
    is_stack = (EA_REG == 3'h7);
    active_stack_ptr = st.status_word[SW_SUPER_BIT] ? st.super_stack_ptr : st.user_stack_ptr;
    // Register field 7 in address modes means the active stack pointer
    base_reg = read_reg(st, {1'b1, EA_REG});
    index_val = read_reg(st, INDEX_SEL);
    if (!INDEX_LONG)
    begin
      index_val = {{16{index_val[15]}}, index_val[15:0]};
    end
    long_displacement = {{16{EXT_WORD0[15]}}, EXT_WORD0};
    short_displacement = {{24{EXT_WORD0[7]}}, EXT_WORD0[7:0]};
  end

  always_comb
  begin
    logic [31:0] wv;
    logic [31:0] cur;
    logic [3:0] asel;
    wv = 32'h0000_0000;
    cur = 32'h0000_0000;
    asel = {1'b1, EA_REG};
    next_st = st;
    next_st.ea_valid = 1'b0;
    if (EA_START)
    begin
      next_st.ea_valid = 1'b1;
      next_st.mem_access = 1'b1;
      next_st.operand = 32'h0000_0000;
      case (EA_MODE)
        MODE_DATA_DIRECT:
        begin
          next_st.mem_access = 1'b0;
          next_st.effective_addr = 32'h0000_0000;
          next_st.operand = st.regs[{1'b0, EA_REG}];
        end
        MODE_ADDR_DIRECT:
        begin
          next_st.mem_access = 1'b0;
          next_st.effective_addr = 32'h0000_0000;
          next_st.operand = base_reg;
        end
        MODE_INDIRECT: next_st.effective_addr = base_reg;
        MODE_POSTINC:
        begin
          next_st.effective_addr = base_reg;
          wv = base_reg + step;
        end
        MODE_PREDEC:
        begin
          wv = base_reg - step;
          next_st.effective_addr = wv;
        end
        MODE_OFFSET: next_st.effective_addr = base_reg + long_displacement;
        MODE_INDEXED: next_st.effective_addr = base_reg + index_val + short_displacement;
        MODE_ABS_SHORT: next_st.effective_addr = long_displacement;
        MODE_ABS_LONG: next_st.effective_addr = {EXT_WORD0, EXT_WORD1};
        MODE_PC_OFFSET: next_st.effective_addr = st.program_counter + long_displacement;
        MODE_PC_INDEXED:
        begin
          next_st.effective_addr = st.program_counter + index_val + short_displacement;
        end
        MODE_IMMEDIATE:
        begin
          next_st.mem_access = 1'b0;
          next_st.effective_addr = 32'h0000_0000;
          next_st.operand = (OP_SIZE == SIZE_LONG) ? {EXT_WORD0, EXT_WORD1} : {16'h0000, EXT_WORD0};
          if (OP_SIZE == SIZE_BYTE)
          begin
            next_st.operand = {24'h000000, EXT_WORD0[7:0]};
          end
        end
        MODE_QUICK:
        begin
          next_st.mem_access = 1'b0;
          next_st.effective_addr = 32'h0000_0000;
          next_st.operand = {{24{QUICK_DATA[7]}}, QUICK_DATA};
        end
        MODE_IMPLIED:
        begin
          next_st.mem_access = 1'b0;
          next_st.effective_addr = 32'h0000_0000;
          case (IMPLIED_SEL)
            IMPL_STATUS: next_st.operand = {16'h0000, st.status_word};
            IMPL_USER_STACK: next_st.operand = st.user_stack_ptr;
            IMPL_ACTIVE_STACK: next_st.operand = active_stack_ptr;
            default: next_st.operand = st.program_counter;
          endcase
        end
        default:
        begin
          next_st.ea_valid = 1'b0;
          next_st.mem_access = 1'b0;
        end
      endcase
      if (EA_MODE == MODE_POSTINC || EA_MODE == MODE_PREDEC)
      begin
        if (asel == SEL_ACTIVE_STACK && st.status_word[SW_SUPER_BIT])
        begin
          next_st.super_stack_ptr = wv;
        end
        else if (asel == SEL_ACTIVE_STACK)
        begin
          next_st.user_stack_ptr = wv;
        end
        else
        begin
          next_st.regs[asel] = wv;
        end
      end
    end
    // Sequencer write port; takes priority over the address update
    if (WR_EN)
    begin
      cur = read_reg(st, WR_SEL);
      if (!WR_SEL[3])
      begin
        case (WR_SIZE)
          SIZE_BYTE: wv = {cur[31:8], WR_DATA[7:0]};
          SIZE_WORD: wv = {cur[31:16], WR_DATA[15:0]};
          default: wv = WR_DATA;
        endcase
      end
      else
      begin
        // No byte size on address registers; treated as word
        wv = (WR_SIZE == SIZE_LONG) ? WR_DATA : {{16{WR_DATA[15]}}, WR_DATA[15:0]};
      end
      if (WR_SEL == SEL_ACTIVE_STACK && st.status_word[SW_SUPER_BIT])
      begin
        next_st.super_stack_ptr = wv;
      end
      else if (WR_SEL == SEL_ACTIVE_STACK)
      begin
        next_st.user_stack_ptr = wv;
      end
      else
      begin
        next_st.regs[WR_SEL] = wv;
      end
    end
    if (USP_WR)
    begin
      next_st.user_stack_ptr = USP_DATA;
    end
    if (PC_WR)
    begin
      next_st.program_counter = PC_DATA;
    end
    if (SW_WR)
    begin
      next_st.status_word = SW_DATA & SW_IMPL_MASK;
    end
    // Slot 15 of the array is never used; stack lives in its own registers
    next_st.regs[SEL_ACTIVE_STACK] = REG_RESET;
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      st <= '0;
      st.status_word <= STATUS_RESET;
      st.program_counter <= PC_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign ADDR_BUS = st.effective_addr[ADDR_BUS_W:1];
  assign EFFECTIVE_ADDR = st.effective_addr;
  assign OPERAND = st.operand;
  assign EA_VALID = st.ea_valid;
  assign MEM_ACCESS = st.mem_access;
  assign STATUS_WORD = st.status_word;
  assign PROGRAM_COUNTER = st.program_counter;
  assign INT_MASK = st.status_word[SW_MASK_LO +: SW_MASK_W];
  assign TRACE_MODE = st.status_word[SW_TRACE_BIT];
  assign SUPERVISOR = st.status_word[SW_SUPER_BIT];

  property direct_no_mem;
    @(posedge CORE_CLK) disable iff (RESET)
    (EA_START && (EA_MODE == MODE_DATA_DIRECT || EA_MODE == MODE_ADDR_DIRECT)) |=> (EA_VALID && !MEM_ACCESS);
  endproperty
  direct_access_a: assert property (direct_no_mem) else $error("register direct made memory access");

  sequence postinc_req;
    EA_START && EA_MODE == MODE_POSTINC && EA_REG != 3'h7 && !WR_EN && OP_SIZE == SIZE_LONG;
  endsequence
  postinc_step_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    postinc_req |=> (st.regs[{1'b1, $past(EA_REG)}] == EFFECTIVE_ADDR + 32'h4))
    else $error("postincrement wrong");

  predec_addr_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (EA_START && EA_MODE == MODE_PREDEC && EA_REG != 3'h7 && OP_SIZE == SIZE_WORD)
    |=> EFFECTIVE_ADDR == $past(base_reg) - 32'h2) else $error("predecrement address wrong");

  stack_byte_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (EA_START && EA_MODE == MODE_PREDEC && EA_REG == 3'h7 && OP_SIZE == SIZE_BYTE)
    |=> EFFECTIVE_ADDR == $past(active_stack_ptr) - 32'h2) else $error("stack pointer lost alignment");

  data_byte_keep_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (WR_EN && !WR_SEL[3] && WR_SIZE == SIZE_BYTE && !EA_START)
    |=> st.regs[$past(WR_SEL)][31:8] == $past(st.regs[WR_SEL][31:8]))
    else $error("byte write changed upper bits");

  addr_word_ext_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (WR_EN && WR_SEL[2:0] != 3'h7 && WR_SEL[3] && WR_SIZE == SIZE_WORD && !EA_START)
    |=> st.regs[$past(WR_SEL)] == {{16{$past(WR_DATA[15])}}, $past(WR_DATA[15:0])})
    else $error("address word not extended");

  abs_long_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (EA_START && EA_MODE == MODE_ABS_LONG)
    |=> EFFECTIVE_ADDR == {$past(EXT_WORD0), $past(EXT_WORD1)}) else $error("absolute long wrong");

  bus_follows_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    (EA_START && EA_MODE == MODE_ABS_SHORT)
    |=> ADDR_BUS == {{8{$past(EXT_WORD0[15])}}, $past(EXT_WORD0[15:1])}) else $error("address bus wrong");

  mask_load_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    SW_WR |=> INT_MASK == $past(SW_DATA[10:8]) && TRACE_MODE == $past(SW_DATA[15]))
    else $error("status mask wrong");

endmodule // cpu_register_model_ea_gen

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench
  import cpu_regs_pkg::*;
;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic EA_START = 1'b0;
  logic [3:0] EA_MODE = 4'h0;
  logic [1:0] OP_SIZE = 2'h0;
  logic [2:0] EA_REG = 3'h0;
  logic [3:0] INDEX_SEL = 4'h0;
  logic INDEX_LONG = 1'b0;
  logic [1:0] IMPLIED_SEL = 2'h0;
  logic [15:0] EXT_WORD0 = 16'h0;
  logic [15:0] EXT_WORD1 = 16'h0;
  logic [7:0] QUICK_DATA = 8'h0;
  logic WR_EN = 1'b0;
  logic [3:0] WR_SEL = 4'h0;
  logic [1:0] WR_SIZE = 2'h0;
  logic [31:0] WR_DATA = 32'h0;
  logic PC_WR = 1'b0;
  logic [31:0] PC_DATA = 32'h0;
  logic SW_WR = 1'b0;
  logic [15:0] SW_DATA = 16'h0;
  logic USP_WR = 1'b0;
  logic [31:0] USP_DATA = 32'h0;
  logic [22:0] ADDR_BUS;
  logic [31:0] EFFECTIVE_ADDR;
  logic [31:0] OPERAND;
  logic EA_VALID;
  logic MEM_ACCESS;
  logic [15:0] STATUS_WORD;
  logic [31:0] PROGRAM_COUNTER;
  logic [2:0] INT_MASK;
  logic TRACE_MODE;
  logic SUPERVISOR;
  int err_total = 0;
  int n_compared = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  cpu_register_model_ea_gen cpu_register_model_ea_gen_inst (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .EA_START(EA_START), .EA_MODE(EA_MODE), .OP_SIZE(OP_SIZE), .EA_REG(EA_REG), .INDEX_SEL(INDEX_SEL),
    .INDEX_LONG(INDEX_LONG), .IMPLIED_SEL(IMPLIED_SEL), .EXT_WORD0(EXT_WORD0), .EXT_WORD1(EXT_WORD1),
    .QUICK_DATA(QUICK_DATA), .WR_EN(WR_EN), .WR_SEL(WR_SEL), .WR_SIZE(WR_SIZE), .WR_DATA(WR_DATA),
    .PC_WR(PC_WR), .PC_DATA(PC_DATA), .SW_WR(SW_WR), .SW_DATA(SW_DATA), .USP_WR(USP_WR),
    .USP_DATA(USP_DATA), .ADDR_BUS(ADDR_BUS), .EFFECTIVE_ADDR(EFFECTIVE_ADDR), .OPERAND(OPERAND),
    .EA_VALID(EA_VALID), .MEM_ACCESS(MEM_ACCESS), .STATUS_WORD(STATUS_WORD),
    .PROGRAM_COUNTER(PROGRAM_COUNTER), .INT_MASK(INT_MASK), .TRACE_MODE(TRACE_MODE),
    .SUPERVISOR(SUPERVISOR));

  task automatic test_done();
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] sel, input logic [1:0] sz, input logic [31:0] d);
    @(posedge CORE_CLK);
    WR_EN <= 1'b1;
    WR_SEL <= sel;
    WR_SIZE <= sz;
    WR_DATA <= d;
    @(posedge CORE_CLK);
    WR_EN <= 1'b0;
  endtask

  // Direct loads: 0 program counter, 1 status word, 2 user stack
  task automatic ld(input int kind, input logic [31:0] d);
    @(posedge CORE_CLK);
    PC_WR <= (kind == 0);
    SW_WR <= (kind == 1);
    USP_WR <= (kind == 2);
    PC_DATA <= d;
    SW_DATA <= d[15:0];
    USP_DATA <= d;
    @(posedge CORE_CLK);
    PC_WR <= 1'b0;
    SW_WR <= 1'b0;
    USP_WR <= 1'b0;
  endtask

  // Index select doubles as implied select, word0 low byte as quick data
  task automatic ea(input logic [3:0] m, input logic [1:0] s, input logic [2:0] r, input logic [3:0] x,
                    input logic il, input logic [15:0] w0, input logic [15:0] w1, input logic [31:0] exp);
    int i;
    @(posedge CORE_CLK);
    EA_START <= 1'b1;
    EA_MODE <= m;
    OP_SIZE <= s;
    EA_REG <= r;
    INDEX_SEL <= x;
    INDEX_LONG <= il;
    IMPLIED_SEL <= x[1:0];
    EXT_WORD0 <= w0;
    EXT_WORD1 <= w1;
    QUICK_DATA <= w0[7:0];
    @(posedge CORE_CLK);
    EA_START <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      @(negedge CORE_CLK);
      if (EA_VALID === 1'b1)
        break;
    end
    if (i == 4)
    begin
      chk(32'h0, 32'h1, "no valid strobe");
      test_done();
    end
    chk(EFFECTIVE_ADDR, exp, "address");
    chk({9'h0, ADDR_BUS}, {9'h0, exp[23:1]}, "address bus");
  endtask

  initial
  begin
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
    chk({16'h0, STATUS_WORD}, 32'h2700, "reset status");
    chk({29'h0, INT_MASK}, 32'h7, "reset mask");
    chk({31'h0, SUPERVISOR}, 32'h1, "reset supervisor");
    chk(PROGRAM_COUNTER, 32'h0, "reset pc");
    wr(4'h0, SIZE_LONG, 32'h11223344);
    wr(4'h0, SIZE_BYTE, 32'hffffffaa);
    wr(4'h0, SIZE_WORD, 32'h0000beef);
    ea(MODE_DATA_DIRECT, SIZE_LONG, 3'h0, 4'h0, 1'b0, 16'h0, 16'h0, 32'h0);
    chk(OPERAND, 32'h1122beef, "narrow writes");
    chk({31'h0, MEM_ACCESS}, 32'h0, "direct no access");
    wr(4'h8, SIZE_WORD, 32'h00008000);
    ea(MODE_ADDR_DIRECT, SIZE_LONG, 3'h0, 4'h0, 1'b0, 16'h0, 16'h0, 32'h0);
    chk(OPERAND, 32'hffff8000, "address word write");
    wr(4'ha, SIZE_LONG, 32'h00001000);
    ea(MODE_POSTINC, SIZE_LONG, 3'h2, 4'h0, 1'b0, 16'h0, 16'h0, 32'h00001000);
    chk({31'h0, MEM_ACCESS}, 32'h1, "memory access");
    ea(MODE_POSTINC, SIZE_BYTE, 3'h2, 4'h0, 1'b0, 16'h0, 16'h0, 32'h00001004);
    ea(MODE_PREDEC, SIZE_WORD, 3'h2, 4'h0, 1'b0, 16'h0, 16'h0, 32'h00001003);
    ea(MODE_INDIRECT, SIZE_LONG, 3'h2, 4'h0, 1'b0, 16'h0, 16'h0, 32'h00001003);
    wr(4'hf, SIZE_LONG, 32'h00002000);
    ea(MODE_PREDEC, SIZE_BYTE, 3'h7, 4'h0, 1'b0, 16'h0, 16'h0, 32'h00001ffe);
    ea(MODE_OFFSET, SIZE_LONG, 3'h2, 4'h0, 1'b0, 16'hfff0, 16'h0, 32'h00000ff3);
    wr(4'h1, SIZE_LONG, 32'h00018000);
    ea(MODE_INDEXED, SIZE_WORD, 3'h2, 4'h1, 1'b0, 16'h00fe, 16'h0, 32'hffff9001);
    ea(MODE_INDEXED, SIZE_WORD, 3'h2, 4'ha, 1'b1, 16'h00fe, 16'h0, 32'h00002004);
    ea(MODE_INDEXED, SIZE_WORD, 3'h2, 4'hf, 1'b1, 16'h0010, 16'h0, 32'h00003011);
    ea(MODE_ABS_SHORT, SIZE_WORD, 3'h0, 4'h0, 1'b0, 16'h1234, 16'h0, 32'h00001234);
    ea(MODE_ABS_LONG, SIZE_WORD, 3'h0, 4'h0, 1'b0, 16'h0012, 16'h3456, 32'h00123456);
    ld(0, 32'h00400000);
    ea(MODE_PC_OFFSET, SIZE_WORD, 3'h0, 4'h0, 1'b0, 16'h8000, 16'h0, 32'h003f8000);
    ea(MODE_PC_INDEXED, SIZE_WORD, 3'h0, 4'ha, 1'b1, 16'h0010, 16'h0, 32'h00401013);
    ea(MODE_IMMEDIATE, SIZE_LONG, 3'h0, 4'h0, 1'b0, 16'hcafe, 16'hf00d, 32'h0);
    chk(OPERAND, 32'hcafef00d, "immediate");
    ea(MODE_IMMEDIATE, SIZE_WORD, 3'h0, 4'h0, 1'b0, 16'hbeef, 16'hf00d, 32'h0);
    chk(OPERAND, 32'h0000beef, "immediate word");
    ea(MODE_IMMEDIATE, SIZE_BYTE, 3'h0, 4'h0, 1'b0, 16'hbeef, 16'hf00d, 32'h0);
    chk(OPERAND, 32'h000000ef, "immediate byte");
    ea(MODE_QUICK, SIZE_LONG, 3'h0, 4'h0, 1'b0, 16'h0080, 16'h0, 32'h0);
    chk(OPERAND, 32'hffffff80, "quick");
    ld(2, 32'h00005554);
    ea(MODE_IMPLIED, SIZE_LONG, 3'h0, 4'h1, 1'b0, 16'h0, 16'h0, 32'h0);
    chk(OPERAND, 32'h00005554, "implied user stack");
    ea(MODE_IMPLIED, SIZE_LONG, 3'h0, 4'h3, 1'b0, 16'h0, 16'h0, 32'h0);
    chk(OPERAND, 32'h00400000, "implied pc");
    ea(MODE_IMPLIED, SIZE_LONG, 3'h0, 4'h2, 1'b0, 16'h0, 16'h0, 32'h0);
    chk(OPERAND, 32'h00001ffe, "implied supervisor stack");
    ea(MODE_POSTINC, SIZE_BYTE, 3'h7, 4'h0, 1'b0, 16'h0, 16'h0, 32'h00001ffe);
    ea(MODE_IMPLIED, SIZE_LONG, 3'h0, 4'h2, 1'b0, 16'h0, 16'h0, 32'h0);
    chk(OPERAND, 32'h00002000, "stack byte step");
    ea(MODE_IMPLIED, SIZE_WORD, 3'h0, 4'h0, 1'b0, 16'h0, 16'h0, 32'h0);
    chk(OPERAND, 32'h00002700, "implied status");
    ld(1, 32'h0000ffff);
    @(negedge CORE_CLK);
    chk({16'h0, STATUS_WORD}, 32'ha71f, "status reserved bits");
    chk({31'h0, TRACE_MODE}, 32'h1, "trace flag");
    ld(1, 32'h00000000);
    @(negedge CORE_CLK);
    chk({31'h0, SUPERVISOR}, 32'h0, "user state");
    chk({29'h0, INT_MASK}, 32'h0, "mask cleared");
    ea(MODE_IMPLIED, SIZE_LONG, 3'h0, 4'h2, 1'b0, 16'h0, 16'h0, 32'h0);
    chk(OPERAND, 32'h00005554, "implied user stack active");
    @(posedge CORE_CLK);
    EA_START <= 1'b1;
    EA_MODE <= 4'hf;
    @(posedge CORE_CLK);
    EA_START <= 1'b0;
    repeat (2)
    begin
      @(negedge CORE_CLK);
      chk({31'h0, EA_VALID}, 32'h0, "undefined mode refused");
    end
    test_done();
  end
endmodule // testbench
